// file: rtl/ccp_map.svh
// Register offsets, field positions, reset values and codes of the capture/compare/PWM unit.
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH

`define CCP_CTRL_IDX        8'h17
`define CCP_LOW_IDX         8'h15
`define CCP_HIGH_IDX        8'h16
`define CCP_STAT_IDX        8'h18
`define CCP_MASK_IDX        8'h19
`define CCP_CTRL_RESET      8'h00
`define CCP_CTRL_WMASK      8'h3F
`define CCP_DUTY_LSB        4
`define CCP_MODE_LSB        0
`define CCP_MODE_OFF        4'h0
`define CCP_MODE_CAP_FALL   4'h4
`define CCP_MODE_CAP_RISE   4'h5
`define CCP_MODE_CAP_4TH    4'h6
`define CCP_MODE_CAP_16TH   4'h7
`define CCP_MODE_CMP_SET    4'h8
`define CCP_MODE_CMP_CLR    4'h9
`define CCP_MODE_CMP_SOFT   4'hA
`define CCP_MODE_CMP_TRIG   4'hB
`define CCP_PRESCALE_4      4'h3
`define CCP_PRESCALE_16     4'hF
`define CCP_STAT_EVENT_BIT  0

`endif

// file: rtl/ccp_pkg.sv
// Types shared by the capture/compare/PWM unit.
package ccp_pkg;

    typedef struct packed {
        logic [15:0] t1_count;   // Timer1 count.
        logic [9:0]  t2_count;   // Timer2 count extended by two prescaler bits.
        logic        t2_period;  // Pulse at the start of a Timer2 period.
        logic        adc_on;     // Converter switched on.
    } ccp_timers_s;

    typedef struct packed {
        logic t1_reset;  // Pulse that clears the Timer1 count.
        logic adc_start; // Pulse that starts a conversion.
    } ccp_trig_s;

    typedef enum logic [3:0] {
        CCP_OFF     = 4'b0001,
        CCP_CAPTURE = 4'b0010,
        CCP_COMPARE = 4'b0100,
        CCP_PWM     = 4'b1000
    } ccp_kind_e;

endpackage : ccp_pkg

// file: rtl/ccp_edge.sv
// Pin edge detector with capture prescaler.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_map.svh"

module ccp_edge (
    input  wire logic       pclk,      // Clock.
    input  wire logic       presetn,   // Asynchronous reset, active low.
    input  wire logic       clear,     // Unit not in a capture mode: resets prescaler.
    input  wire logic [3:0] mode,      // Mode field.
    input  wire logic       pin_in,    // Pin level, synchronous.
    output logic            cap_event  // One-cycle capture event.
);
    logic       pin_q;
    logic [3:0] pre_q;
    logic       rise;
    logic       fall;
    logic [3:0] limit;

    assign rise = pin_in & ~pin_q;
    assign fall = ~pin_in & pin_q;

    always_comb begin
        case (mode)
            `CCP_MODE_CAP_4TH:  limit = `CCP_PRESCALE_4;
            `CCP_MODE_CAP_16TH: limit = `CCP_PRESCALE_16;
            default:            limit = 4'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_in;
        end
    end

    // Prescaler counts rising edges; leaving the capture modes or reaching the limit at a capture restarts it from a clean count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 4'h0;
        end else if (clear) begin
            pre_q <= 4'h0;
        end else if (rise && (mode == `CCP_MODE_CAP_4TH || mode == `CCP_MODE_CAP_16TH)) begin
            pre_q <= (pre_q == limit) ? 4'h0 : pre_q + 4'h1;
        end
    end

    always_comb begin
        case (mode)
            `CCP_MODE_CAP_FALL:  cap_event = fall;
            `CCP_MODE_CAP_RISE:  cap_event = rise;
            `CCP_MODE_CAP_4TH,
            `CCP_MODE_CAP_16TH:  cap_event = rise && (pre_q == limit);
            default:             cap_event = 1'b0;
        endcase
    end
endmodule // ccp_edge

`default_nettype wire

// file: rtl/ccp_unit.sv
// Capture/compare/PWM unit with APB register access.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_map.svh"

module ccp_unit (
    input  wire logic                pclk,      // Clock, 125 MHz.
    input  wire logic                presetn,   // Asynchronous reset, active low.
    input  wire logic                psel,      // APB select.
    input  wire logic                penable,   // APB enable.
    input  wire logic                pwrite,    // APB direction.
    input  wire logic [11:0]         paddr,     // APB byte address.
    input  wire logic [31:0]         pwdata,    // APB write data.
    output logic      [31:0]         prdata,    // APB read data.
    output logic                     pready,    // APB ready.
    output logic                     pslverr,   // APB error for unmapped address.
    input  wire ccp_pkg::ccp_timers_s timers,   // Timer state from the chip.
    input  wire logic                pin_in,    // Unit pin input level.
    output logic                     unit_pin,  // Unit pin output level.
    output var ccp_pkg::ccp_trig_s   trig,      // Special-event pulses.
    output logic                     irq        // Level interrupt.
);
    import ccp_pkg::*;

    logic [7:0]  ctrl_q;
    logic [7:0]  low_q;
    logic [7:0]  high_q;
    logic [7:0]  duty_hi_q;
    logic [1:0]  duty_lo_q;
    logic        stat_q;
    logic        mask_q;
    logic        pin_q;
    ccp_trig_s   trig_q;
    logic        irq_q;
    logic [31:0] rdata_q;
    logic        ready_q;
    logic        err_q;
    logic [3:0]  mode;
    ccp_kind_e   kind;
    logic        cap_event;
    logic        match;
    logic        event_set;
    logic        setup;
    logic        wr;
    logic [9:0]  idx;
    logic        mapped;
    logic        wr_ctrl;
    logic        wr_low;
    logic        wr_high;
    logic        access;
    logic        wr_stat;
    logic        wr_mask;
    logic        pwm_match;

    assign mode  = ctrl_q[`CCP_MODE_LSB +: 4];
    assign setup = psel && !penable;
    assign idx   = paddr[11:2];
    // Registers change only at the edge where the master sees pready, as the bus defines.
    assign access = psel && penable && ready_q;
    assign wr    = access && pwrite && mapped;

    assign mapped  = (idx == {2'b00, `CCP_CTRL_IDX}) || (idx == {2'b00, `CCP_LOW_IDX})
                  || (idx == {2'b00, `CCP_HIGH_IDX}) || (idx == {2'b00, `CCP_STAT_IDX})
                  || (idx == {2'b00, `CCP_MASK_IDX});
    assign wr_ctrl = wr && idx == {2'b00, `CCP_CTRL_IDX};
    assign wr_low  = wr && idx == {2'b00, `CCP_LOW_IDX};
    assign wr_high = wr && idx == {2'b00, `CCP_HIGH_IDX};
    assign wr_stat = wr && idx == {2'b00, `CCP_STAT_IDX};
    assign wr_mask = wr && idx == {2'b00, `CCP_MASK_IDX};

    always_comb begin
        if (mode == `CCP_MODE_OFF) begin
            kind = CCP_OFF;
        end else if (mode[3:2] == 2'b11) begin
            kind = CCP_PWM;
        end else if (mode[3]) begin
            kind = CCP_COMPARE;
        end else if (mode[2]) begin
            kind = CCP_CAPTURE;
        end else begin
            kind = CCP_OFF;
        end
    end

    ccp_edge u_edge (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (kind != CCP_CAPTURE),
        .mode      (mode),
        .pin_in    (pin_in),
        .cap_event (cap_event)
    );

    // A match while Timer1 is held on the pair raises one event per entry, not per cycle.
    logic match_q;
    assign match = (kind == CCP_COMPARE) && (timers.t1_count == {high_q, low_q});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end
    assign event_set = cap_event || (match && !match_q);

    // APB slave: answers in the access cycle, one wait-free phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= setup;
            err_q   <= setup && !mapped;
            rdata_q <= 32'h0000_0000;
            if (setup && !pwrite) begin
                case (idx)
                    {2'b00, `CCP_CTRL_IDX}: rdata_q <= {24'h00_0000, 2'b00, ctrl_q[5:0]};
                    {2'b00, `CCP_LOW_IDX}:  rdata_q <= {24'h00_0000, low_q};
                    {2'b00, `CCP_HIGH_IDX}: rdata_q <= {24'h00_0000, high_q};
                    {2'b00, `CCP_STAT_IDX}: rdata_q <= {31'h0000_0000, stat_q};
                    {2'b00, `CCP_MASK_IDX}: rdata_q <= {31'h0000_0000, mask_q};
                    default:                rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CCP_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0] & `CCP_CTRL_WMASK;
        end
    end

    // The pair: software writes each byte; capture overwrites both at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q  <= 8'h00;
            high_q <= 8'h00;
        end else if (cap_event) begin
            {high_q, low_q} <= timers.t1_count;
        end else begin
            if (wr_low) begin
                low_q <= pwdata[7:0];
            end
            if (wr_high) begin
                high_q <= pwdata[7:0];
            end
        end
    end

    // Duty is latched at period start so a glitching mid-period write cannot truncate a pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_hi_q <= 8'h00;
            duty_lo_q <= 2'b00;
        end else if (kind != CCP_PWM) begin
            duty_hi_q <= 8'h00;
            duty_lo_q <= 2'b00;
        end else if (timers.t2_period) begin
            duty_hi_q <= low_q;
            duty_lo_q <= ctrl_q[`CCP_DUTY_LSB +: 2];
        end
    end
    assign pwm_match = (timers.t2_count == {duty_hi_q, duty_lo_q});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            case (kind)
                CCP_OFF: pin_q <= 1'b0;
                CCP_CAPTURE: pin_q <= 1'b0;
                CCP_COMPARE: begin
                    if (match && !match_q && mode == `CCP_MODE_CMP_SET) begin
                        pin_q <= 1'b1;
                    end else if (match && !match_q && mode == `CCP_MODE_CMP_CLR) begin
                        pin_q <= 1'b0;
                    end
                end
                CCP_PWM: begin
                    if (timers.t2_period) begin
                        pin_q <= (ctrl_q[`CCP_DUTY_LSB +: 2] != 2'b00) || (low_q != 8'h00);
                    end else if (pwm_match) begin
                        pin_q <= 1'b0;
                    end
                end
                default: pin_q <= 1'b0;
            endcase
        end
    end
    assign unit_pin = pin_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q <= '0;
        end else begin
            trig_q.t1_reset  <= match && !match_q && mode == `CCP_MODE_CMP_TRIG;
            trig_q.adc_start <= match && !match_q && mode == `CCP_MODE_CMP_TRIG
                                && timers.adc_on;
        end
    end
    assign trig = trig_q;

    // Event flag: a set in the same cycle as a write-one clear wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 1'b0;
        end else if (event_set) begin
            stat_q <= 1'b1;
        end else if (wr_stat && pwdata[`CCP_STAT_EVENT_BIT]) begin
            stat_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask_q <= pwdata[`CCP_STAT_EVENT_BIT];
            end
            irq_q <= stat_q && mask_q;
        end
    end
    assign irq = irq_q;

    // Register file and bus answer.
    a_ctrl_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[7:6] == 2'b00)
        else $error("control top bits not zero");

    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> ctrl_q == ($past(pwdata[7:0]) & `CCP_CTRL_WMASK))
        else $error("control write lost");

    a_pair_low_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_low && !cap_event |=> low_q == $past(pwdata[7:0]))
        else $error("low byte write lost");

    a_pair_high_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_high && !cap_event |=> high_q == $past(pwdata[7:0]))
        else $error("high byte write lost");

    a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("no ready after setup");

    a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held too long");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");

    // Mode behaviour of off, capture and compare.
    a_off_pin_low: assert property (@(posedge pclk) disable iff (!presetn)
        kind == CCP_OFF |=> !unit_pin)
        else $error("pin not low when off");

    a_off_no_event: assert property (@(posedge pclk) disable iff (!presetn)
        kind == CCP_OFF |-> !event_set)
        else $error("event while off");

    a_capture_pin_low: assert property (@(posedge pclk) disable iff (!presetn)
        kind == CCP_CAPTURE |=> !unit_pin)
        else $error("pin driven in capture");

    a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
        cap_event |=> {high_q, low_q} == $past(timers.t1_count) && stat_q)
        else $error("capture did not copy timer");

    a_cmp_set_pin: assert property (@(posedge pclk) disable iff (!presetn)
        match && !match_q && mode == `CCP_MODE_CMP_SET |=> unit_pin && stat_q)
        else $error("set on match failed");

    a_cmp_clr_pin: assert property (@(posedge pclk) disable iff (!presetn)
        match && !match_q && mode == `CCP_MODE_CMP_CLR |=> !unit_pin && stat_q)
        else $error("clear on match failed");

    a_soft_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
        mode == `CCP_MODE_CMP_SOFT && $past(mode) == `CCP_MODE_CMP_SOFT |-> $stable(unit_pin))
        else $error("soft mode moved pin");

    a_trig_event: assert property (@(posedge pclk) disable iff (!presetn)
        match && !match_q && mode == `CCP_MODE_CMP_TRIG |=> trig.t1_reset && trig.adc_start == $past(timers.adc_on))
        else $error("special event wrong");

    a_trig_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !(match && !match_q && mode == `CCP_MODE_CMP_TRIG)
        |=> !trig.t1_reset && !trig.adc_start)
        else $error("special event without match");

    // Pulse-width behaviour.
    a_pwm_decode: assert property (@(posedge pclk) disable iff (!presetn)
        mode[3:2] == 2'b11 |-> kind == CCP_PWM)
        else $error("pwm mode not decoded");

    a_pwm_period: assert property (@(posedge pclk) disable iff (!presetn)
        kind == CCP_PWM && timers.t2_period && low_q != 8'h00 |=> unit_pin)
        else $error("pwm pin not high at period");

    a_pwm_duty_end: assert property (@(posedge pclk) disable iff (!presetn)
        kind == CCP_PWM && !timers.t2_period && pwm_match |=> !unit_pin)
        else $error("pwm pin not low at duty");

    a_duty_idle: assert property (@(posedge pclk) disable iff (!presetn)
        kind != CCP_PWM |=> duty_hi_q == 8'h00 && duty_lo_q == 2'b00)
        else $error("duty held outside pwm");

    // Event flag and interrupt.
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        event_set |=> stat_q)
        else $error("event flag not set");

    a_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_stat && pwdata[`CCP_STAT_EVENT_BIT] && !event_set |=> !stat_q)
        else $error("event flag not cleared");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        stat_q && mask_q |=> irq)
        else $error("interrupt not raised");

    a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        !(stat_q && mask_q) |=> !irq)
        else $error("interrupt raised while masked");
endmodule // ccp_unit

`default_nettype wire

// file: sim/ccp_pin_model.sv
// Behavioural source of the level seen on the unit pin input.
`timescale 1ns/1ps
`default_nettype none

module ccp_pin_model (
    input  wire logic pclk,   // Clock.
    output logic      pin_in  // Pin level towards the unit.
);
    initial pin_in = 1'b0;

    // Gap sets how slowly the far side toggles, so prompt and lazy edges both occur.
    task automatic pulse(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge pclk);
            pin_in <= 1'b1;
            repeat (gap) @(posedge pclk);
            pin_in <= 1'b0;
        end
    endtask
endmodule // ccp_pin_model

`default_nettype wire

// file: sim/tb_top.sv
// Self-checking testbench of the capture/compare/PWM unit.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_map.svh"

module tb_top;
    import ccp_pkg::*;

    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    ccp_timers_s        timers = '0;
    logic               pin_in;
    logic               unit_pin;
    ccp_trig_s          trig;
    logic               irq;
    logic [32:0]        exp_q[$];
    int                 err_total = 0;
    int                 check_count = 0;
    logic               seen_t1r = 1'b0;
    logic               seen_adc = 1'b0;
    logic [15:0]        val;
    logic [9:0]         duty;
    int                 nums[4] = '{1, 1, 4, 16};

    localparam logic [11:0] A_CTRL = {2'b00, `CCP_CTRL_IDX, 2'b00};
    localparam logic [11:0] A_LOW  = {2'b00, `CCP_LOW_IDX, 2'b00};
    localparam logic [11:0] A_HIGH = {2'b00, `CCP_HIGH_IDX, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, `CCP_STAT_IDX, 2'b00};
    localparam logic [11:0] A_MASK = {2'b00, `CCP_MASK_IDX, 2'b00};

    always #4 pclk = ~pclk;

    ccp_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timers(timers), .pin_in(pin_in), .unit_pin(unit_pin),
        .trig(trig), .irq(irq));

    ccp_pin_model u_pin (.pclk(pclk), .pin_in(pin_in));

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // The request is held until pready is seen high, then released at that edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
        exp_q.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, exp_q.pop_front());
        if (trig.t1_reset === 1'b1) seen_t1r <= 1'b1;
        if (trig.adc_start === 1'b1) seen_adc <= 1'b1;
    end

    initial begin
        #(8 * 30000);
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hece87ae1));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_CTRL, 32'h0, 1'b0);
        apb(1'b1, A_CTRL, 32'hFF);
        rd(A_CTRL, 32'h3F, 1'b0);
        apb(1'b1, A_CTRL, 32'h0);
        val = 16'($urandom());
        apb(1'b1, A_LOW, {24'h0, val[7:0]});
        apb(1'b1, A_HIGH, {24'h0, val[15:8]});
        rd(A_LOW, {24'h0, val[7:0]}, 1'b0);
        rd(A_HIGH, {24'h0, val[15:8]}, 1'b0);
        rd(12'h000, 32'h0, 1'b1);
        apb(1'b1, A_MASK, 32'h1);
        // Capture: all four edge modes; the off mode between them clears the prescaler.
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, A_CTRL, 32'h0);
            apb(1'b1, A_CTRL, 32'(`CCP_MODE_CAP_FALL + i));
            if (nums[i] > 1) begin
                timers.t1_count <= 16'($urandom());
                u_pin.pulse(nums[i] - 1, 1 + i);
                repeat (4) @(posedge pclk);
                rd(A_STAT, 32'h0, 1'b0);
            end
            // The count flips between the rise and the fall, so a capture on the wrong edge shows.
            val = 16'($urandom());
            timers.t1_count <= (i == 0) ? ~val : val;
            fork
                u_pin.pulse(1, 2);
                begin
                    repeat (3) @(posedge pclk);
                    timers.t1_count <= (i == 0) ? val : ~val;
                end
            join
            repeat (4) @(posedge pclk);
            #1 chk(irq, 1'b1);
            rd(A_LOW, {24'h0, val[7:0]}, 1'b0);
            rd(A_HIGH, {24'h0, val[15:8]}, 1'b0);
            rd(A_STAT, 32'h1, 1'b0);
            apb(1'b1, A_STAT, 32'h1);
            repeat (2) @(posedge pclk);
            #1 chk(irq, 1'b0);
        end
        // Compare: duty bits set in the control byte must not matter here.
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b1, A_MASK, 32'h0);
        timers.adc_on <= 1'b1;
        val = 16'($urandom()) | 16'h0100;
        apb(1'b1, A_LOW, {24'h0, val[7:0]});
        apb(1'b1, A_HIGH, {24'h0, val[15:8]});
        foreach (nums[i]) begin
            apb(1'b1, A_CTRL, 32'h30 | 32'(`CCP_MODE_CMP_SET + (i == 1 ? 2 : i == 2 ? 1 : i)));
            @(posedge pclk);
            timers.t1_count <= val;
            @(posedge pclk);
            timers.t1_count <= val + 16'h1;
            repeat (3) @(posedge pclk);
            #1 chk(unit_pin, (i < 2) ? 1'b1 : 1'b0);
            #0 chk(irq, 1'b0);
            rd(A_STAT, 32'h1, 1'b0);
            apb(1'b1, A_STAT, 32'h1);
        end
        chk({seen_t1r, seen_adc}, 2'b11);
        // Pulse-width: duty spans the low byte and control bits 5 and 4.
        duty = 10'(20 + $urandom_range(0, 800));
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b1, A_LOW, {24'h0, duty[9:2]});
        apb(1'b1, A_CTRL, {26'h0, duty[1:0], 4'hD});
        @(posedge pclk);
        timers.t2_count <= 10'h0;
        timers.t2_period <= 1'b1;
        @(posedge pclk);
        timers.t2_period <= 1'b0;
        for (int k = 1; k < duty + 4; k++) begin
            @(posedge pclk);
            timers.t2_count <= 10'(k);
            if (k == duty) #1 chk(unit_pin, 1'b1);
            if (k == duty + 1) #1 chk(unit_pin, 1'b0);
        end
        repeat (2) @(posedge pclk);
        #1 chk(unit_pin, 1'b0);
        repeat (4) @(posedge pclk);
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
